// ===== hw/hap_consts.svh
// Offsets, field positions, reset values and timing counts of the host port.
`ifndef HAP_CONSTS_SVH
`define HAP_CONSTS_SVH

// Register word indices on the Avalon slave (byte address is four times).
`define HAP_REG_CTRL      4'h0
`define HAP_REG_WAITS     4'h1
`define HAP_REG_PAD       4'h2
`define HAP_REG_ADDR      4'h3
`define HAP_REG_WDATA     4'h4
`define HAP_REG_CMD       4'h5
`define HAP_REG_RDATA     4'h6
`define HAP_REG_STATUS    4'h7
`define HAP_REG_SIG       4'h8

// Control register fields.
`define HAP_CTRL_START    0
`define HAP_CTRL_CSSEL_LO 1
`define HAP_CTRL_BOOTBUSY 3
`define HAP_CTRL_CSVALID  4
`define HAP_CTRL_CLRREJ   5

// Command register fields.
`define HAP_CMD_READ      0
`define HAP_CMD_WRITE     1

// Pad register: bit n enables pad n; pads 0..3 are the chip selects.
`define HAP_PAD_ADDR      4
`define HAP_PAD_DATA      5
`define HAP_PAD_CTRL      6

// Reset values.
`define HAP_RST_CTRL      8'h00
`define HAP_RST_PAD       8'h00
`define HAP_RST_RD_WAITS  4'h5
`define HAP_RST_WR_WAITS  4'h1

// Least wait states the device tolerates.
`define HAP_MIN_RD_WAITS  4'h5
`define HAP_MIN_WR_WAITS  4'h1

// Signature values.
`define HAP_SIG_BUSY      16'h0000
`define HAP_SIG_DONE      16'h0815

// System clock generator settings: first locks, second gives 66 MHz.
`define HAP_PLL_CFG_A     32'h1E900000
`define HAP_PLL_CFG_B     32'h1E880000

// Timing: clock rate, base strobe cycles and the write-to-read pause.
`define HAP_CLK_MHZ       10
`define HAP_STRB_BASE     6'h02
`define HAP_WEOE_NS       80
`define HAP_WEOE_CYC      (((`HAP_WEOE_NS * `HAP_CLK_MHZ) + 999) / 1000)

`endif

// ===== hw/hap_pkg.sv
// Types shared by the host port controller modules.
package hap_pkg;

    // Start-up sequence states.
    typedef enum logic [8:0] {
        HAP_I_IDLE  = 9'h001,
        HAP_I_PAD   = 9'h002,
        HAP_I_CS    = 9'h004,
        HAP_I_PLL1  = 9'h008,
        HAP_I_PLLW  = 9'h010,
        HAP_I_PLL2  = 9'h020,
        HAP_I_POLL  = 9'h040,
        HAP_I_READY = 9'h080,
        HAP_I_ERR   = 9'h100
    } hap_init_t;

    // Pin access states.
    typedef enum logic [4:0] {
        HAP_A_IDLE   = 5'h01,
        HAP_A_SETUP  = 5'h02,
        HAP_A_STROBE = 5'h04,
        HAP_A_HOLD   = 5'h08,
        HAP_A_GAP    = 5'h10
    } hap_acc_t;

endpackage

// ===== hw/hap_tmr_if.sv
// Load and done signals between the access sequencer and its timer.
`timescale 1ns/100ps
interface hap_tmr_if;
    logic       load;
    logic [5:0] count;
    logic       done;

    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// ===== hw/hap_strobe_timer.sv
// Down-counter that times strobes and pauses of the pin sequencer.
`timescale 1ns/100ps
module hap_strobe_timer
    import hap_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    hap_tmr_if.tmr    tmr
);

    logic [5:0] cnt_r;

    // Loaded at strobe start and, for writes, again at hold for the pause, then counts down to zero and rests there.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 6'h00;
        end else if (tmr.load) begin
            cnt_r <= tmr.count;
        end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    // A load in the same cycle hides the stale zero from the sequencer.
    assign tmr.done = (cnt_r == 6'h00) && !tmr.load;

endmodule

// ===== hw/hap_host_port.sv
// Host controller for the asynchronous memory host port of the device.
`timescale 1ns/100ps
`include "hap_consts.svh"
module hap_host_port
    import hap_pkg::*;
#(
    parameter int          ADDR_W   = 16,
    parameter int          DATA_W   = 16,
    parameter logic [15:0] SIG_ADDR = 16'h0000
)(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [3:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              pll_lock_i,
    output logic      [31:0]       pll_cfg_o,
    output logic                   dev_rst_n_o,
    output logic      [3:0]        cs_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    input  wire logic [DATA_W-1:0] data_i
);

    // The device port is fixed at sixteen bits; anything else is refused.
    if (DATA_W != 16 || ADDR_W < 1 || ADDR_W > 16) begin : g_bad_width
        $error("hap_host_port: DATA_W must be 16, ADDR_W 1 to 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Raises a programmed wait count to the device's least figure.
    function automatic logic [3:0] clamp_waits(input logic [3:0] v,
                                               input logic [3:0] lo);
        clamp_waits = (v < lo) ? lo : v;
    endfunction

    // Strobe length in cycles less one, ready for the timer load.
    function automatic logic [5:0] strobe_load(input logic [3:0] w);
        strobe_load = `HAP_STRB_BASE + {2'b00, w} - 6'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    hap_init_t         init_r;
    hap_init_t         init_nxt;
    hap_acc_t          acc_r;
    hap_acc_t          acc_nxt;
    hap_tmr_if         tmr ();

    logic [7:0]        ctrl_r;
    logic [7:0]        pad_r;
    logic [3:0]        rd_waits_r;
    logic [3:0]        wr_waits_r;
    logic [15:0]       sw_addr_r;
    logic [15:0]       sw_wdata_r;
    logic [15:0]       rdata_r;
    logic [15:0]       sig_r;
    logic              sw_req_r;
    logic              sw_wr_r;
    logic              rej_r;
    logic              ack_r;
    logic [31:0]       readdata_r;
    logic              start_pls;
    logic              clr_rej;
    logic              req_take;
    logic [3:0]        cs_act_r;
    logic [3:0]        act_rd_w_r;
    logic [3:0]        act_wr_w_r;
    logic              pads_on_r;
    logic              cur_wr_r;
    logic              cur_poll_r;
    logic              lk_s1_r;
    logic              lk_s2_r;
    logic [DATA_W-1:0] din_s1_r;
    logic [DATA_W-1:0] din_s2_r;
    logic              acc_fin;
    logic              poll_req;
    logic              sw_go;
    logic [1:0]        cs_sel;
    logic [31:0]       rd_mux;
    logic              is_wr;
    logic              bus_wr;

    hap_strobe_timer u_timer (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .tmr     (tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then the answer.

    // Waitrequest drops one cycle after the request rises.
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    assign avs_readdata_o    = readdata_r;
    assign bus_wr            = avs_write_i && ack_r;
    assign start_pls = bus_wr && (avs_address_i == `HAP_REG_CTRL) &&
                       avs_writedata_i[`HAP_CTRL_START];
    assign clr_rej   = bus_wr && (avs_address_i == `HAP_REG_CTRL) &&
                       avs_writedata_i[`HAP_CTRL_CLRREJ];
    assign cs_sel    = ctrl_r[`HAP_CTRL_CSSEL_LO +: 2];

    // Ack toggles so each request is answered exactly once.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
        end
    end

    // Read decode; unmapped words read as zero.
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (avs_address_i)
            `HAP_REG_CTRL:   rd_mux = {24'h000000, ctrl_r};
            `HAP_REG_WAITS:  rd_mux = {24'h000000, wr_waits_r, rd_waits_r};
            `HAP_REG_PAD:    rd_mux = {24'h000000, pad_r};
            `HAP_REG_ADDR:   rd_mux = {16'h0000, sw_addr_r};
            `HAP_REG_WDATA:  rd_mux = {16'h0000, sw_wdata_r};
            `HAP_REG_RDATA:  rd_mux = {16'h0000, rdata_r};
            `HAP_REG_STATUS: rd_mux = {16'h0000, 3'h0, init_r,
                                       lk_s2_r, rej_r, sw_req_r,
                                       init_r == HAP_I_READY};
            `HAP_REG_SIG:    rd_mux = {16'h0000, sig_r};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // Read data are latched while waitrequest is still high.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            readdata_r <= 32'h00000000;
        end else if (avs_read_i && !ack_r) begin
            readdata_r <= rd_mux;
        end
    end

    // Configuration registers; the start bit is a pulse and not stored.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r     <= `HAP_RST_CTRL;
            pad_r      <= `HAP_RST_PAD;
            rd_waits_r <= `HAP_RST_RD_WAITS;
            wr_waits_r <= `HAP_RST_WR_WAITS;
            sw_addr_r  <= 16'h0000;
            sw_wdata_r <= 16'h0000;
        end else if (bus_wr) begin
            unique case (avs_address_i)
                `HAP_REG_CTRL:  ctrl_r <= {avs_writedata_i[7:6], 1'b0,
                                           avs_writedata_i[4:1], 1'b0};
                `HAP_REG_WAITS: begin
                    rd_waits_r <= avs_writedata_i[3:0];
                    wr_waits_r <= avs_writedata_i[7:4];
                end
                `HAP_REG_PAD:   pad_r <= avs_writedata_i[7:0];
                `HAP_REG_ADDR:  sw_addr_r <= avs_writedata_i[15:0];
                `HAP_REG_WDATA: sw_wdata_r <= avs_writedata_i[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software commands: refused until the signature has been seen.

    assign sw_go = bus_wr && (avs_address_i == `HAP_REG_CMD) &&
                   (avs_writedata_i[`HAP_CMD_READ] ||
                    avs_writedata_i[`HAP_CMD_WRITE]);

    // One pending command; a refused one sets a sticky flag, set wins.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_req_r <= 1'b0;
            sw_wr_r  <= 1'b0;
            rej_r    <= 1'b0;
        end else begin
            if (sw_go && init_r == HAP_I_READY && !sw_req_r) begin
                sw_req_r <= 1'b1;
                sw_wr_r  <= avs_writedata_i[`HAP_CMD_WRITE];
            end else if (req_take && !poll_req) begin
                sw_req_r <= 1'b0;
            end
            if (sw_go && (init_r != HAP_I_READY || sw_req_r)) begin
                rej_r <= 1'b1;
            end else if (clr_rej) begin
                rej_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the lock flag and the data pins.

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lk_s1_r  <= 1'b0;
            lk_s2_r  <= 1'b0;
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            lk_s1_r  <= pll_lock_i;
            lk_s2_r  <= lk_s1_r;
            din_s1_r <= data_i;
            din_s2_r <= din_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequence: pads, chip select, clock, then signature polling.

    assign acc_fin  = (acc_r == HAP_A_HOLD);
    assign poll_req = (init_r == HAP_I_POLL);

    always_comb begin
        init_nxt = init_r;
        unique case (init_r)
            HAP_I_IDLE, HAP_I_ERR: begin
                if (start_pls) init_nxt = HAP_I_PAD;
            end
            HAP_I_PAD: begin
                // Checked here so a start written with the set-up sees it.
                if (cs_sel == 2'b00 && ctrl_r[`HAP_CTRL_BOOTBUSY]) begin
                    init_nxt = HAP_I_ERR;
                end else if (pad_r[cs_sel] && pad_r[`HAP_PAD_ADDR] &&
                    pad_r[`HAP_PAD_DATA] && pad_r[`HAP_PAD_CTRL]) begin
                    init_nxt = HAP_I_CS;
                end else begin
                    init_nxt = HAP_I_ERR;
                end
            end
            HAP_I_CS: begin
                init_nxt = ctrl_r[`HAP_CTRL_CSVALID] ? HAP_I_PLL1
                                                     : HAP_I_ERR;
            end
            HAP_I_PLL1:  init_nxt = HAP_I_PLLW;
            HAP_I_PLLW:  if (lk_s2_r) init_nxt = HAP_I_PLL2;
            HAP_I_PLL2:  init_nxt = HAP_I_POLL;
            HAP_I_POLL: begin
                // Zero means busy; only the completion value releases.
                if (acc_fin && cur_poll_r && !cur_wr_r &&
                    din_s2_r == `HAP_SIG_DONE) begin
                    init_nxt = HAP_I_READY;
                end
            end
            HAP_I_READY: init_nxt = HAP_I_READY;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_r <= HAP_I_IDLE;
        end else begin
            init_r <= init_nxt;
        end
    end

    // Settings latched by the sequence steps, each at its own step.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pads_on_r   <= 1'b0;
            cs_act_r    <= 4'h0;
            act_rd_w_r  <= `HAP_MIN_RD_WAITS;
            act_wr_w_r  <= `HAP_MIN_WR_WAITS;
            pll_cfg_o   <= 32'h00000000;
            dev_rst_n_o <= 1'b0;
        end else begin
            if (init_r == HAP_I_PAD && init_nxt == HAP_I_CS) begin
                pads_on_r <= 1'b1;
            end
            if (init_r == HAP_I_CS && init_nxt == HAP_I_PLL1) begin
                cs_act_r   <= 4'h1 << cs_sel;
                act_rd_w_r <= clamp_waits(rd_waits_r,
                                          `HAP_MIN_RD_WAITS);
                act_wr_w_r <= clamp_waits(wr_waits_r,
                                          `HAP_MIN_WR_WAITS);
            end
            if (init_r == HAP_I_PLL1) begin
                pll_cfg_o <= `HAP_PLL_CFG_A;
            end
            if (init_r == HAP_I_PLL2) begin
                pll_cfg_o   <= `HAP_PLL_CFG_B;
                dev_rst_n_o <= 1'b1;
            end
            if (init_nxt == HAP_I_ERR) begin
                pads_on_r   <= 1'b0;
                cs_act_r    <= 4'h0;
                dev_rst_n_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin access sequencer.

    // A poll owns the port until ready; software waits for that.
    assign req_take = (acc_r == HAP_A_IDLE) && (poll_req ||
                      (sw_req_r && init_r == HAP_I_READY));
    assign is_wr    = cur_wr_r;

    always_comb begin
        acc_nxt   = acc_r;
        tmr.load  = 1'b0;
        tmr.count = 6'h00;
        unique case (acc_r)
            HAP_A_IDLE:   if (req_take) acc_nxt = HAP_A_SETUP;
            HAP_A_SETUP: begin
                acc_nxt   = HAP_A_STROBE;
                tmr.load  = 1'b1;
                tmr.count = strobe_load(is_wr ? act_wr_w_r
                                              : act_rd_w_r);
            end
            HAP_A_STROBE: if (tmr.done) acc_nxt = HAP_A_HOLD;
            HAP_A_HOLD: begin
                acc_nxt   = is_wr ? HAP_A_GAP : HAP_A_IDLE;
                tmr.load  = is_wr;
                tmr.count = 6'((`HAP_WEOE_CYC) - 1);
            end
            HAP_A_GAP:    if (tmr.done) acc_nxt = HAP_A_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_r <= HAP_A_IDLE;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Access kind and halfword address latched when a request is taken.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_wr_r   <= 1'b0;
            cur_poll_r <= 1'b0;
            addr_o     <= '0;
            data_o     <= '0;
        end else if (req_take) begin
            cur_poll_r <= poll_req;
            cur_wr_r   <= !poll_req && sw_wr_r;
            addr_o     <= poll_req ? SIG_ADDR[ADDR_W-1:0]
                                   : sw_addr_r[ADDR_W-1:0];
            data_o     <= sw_wdata_r;
        end
    end

    // Pin strobes follow the next state so they leave flip-flops cleanly.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_n_o    <= 4'hF;
            oe_n_o    <= 1'b1;
            we_n_o    <= 1'b1;
            data_oe_o <= 1'b0;
        end else begin
            cs_n_o    <= (pads_on_r && acc_nxt != HAP_A_IDLE &&
                          acc_nxt != HAP_A_GAP) ? ~cs_act_r : 4'hF;
            oe_n_o    <= !(acc_nxt == HAP_A_STROBE && !is_wr);
            we_n_o    <= !(acc_nxt == HAP_A_STROBE && is_wr);
            data_oe_o <= is_wr && (acc_nxt == HAP_A_SETUP ||
                          acc_nxt == HAP_A_STROBE ||
                          acc_nxt == HAP_A_HOLD);
        end
    end

    // Read data are caught from the synchroniser as the strobe ends.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 16'h0000;
            sig_r   <= `HAP_SIG_BUSY;
        end else if (acc_fin && !is_wr) begin
            if (cur_poll_r) begin
                sig_r <= din_s2_r;
            end else begin
                rdata_r <= din_s2_r;
            end
        end
    end

endmodule

// ===== sim/hap_sva.sv
// Checker of the host port pins, bound into the controller.
`timescale 1ns/100ps
`include "hap_consts.svh"
module hap_sva #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
)(
    input wire logic              clk_i,
    input wire logic              rst_b_i,
    input wire logic [31:0]       pll_cfg_o,
    input wire logic              dev_rst_n_o,
    input wire logic [3:0]        cs_n_o,
    input wire logic              oe_n_o,
    input wire logic              we_n_o,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic              data_oe_o,
    input wire logic [DATA_W-1:0] data_i
);
    logic done_r;
    // Set once a read strobe sees the completion value on the pins.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_r <= 1'b0;
        end else if (!oe_n_o && data_i == `HAP_SIG_DONE) begin
            done_r <= 1'b1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////
    a_read_waits: assert property (
        $fell(oe_n_o) |-> !oe_n_o [*7]) else $error("read strobe short");
    a_write_waits: assert property (
        $fell(we_n_o) |-> !we_n_o [*3]) else $error("write strobe short");
    a_write_pause: assert property (
        $rose(we_n_o) |-> oe_n_o [*2]) else $error("read too soon");
    a_pll_order: assert property (
        $changed(pll_cfg_o) && pll_cfg_o == `HAP_PLL_CFG_B
        |-> $past(pll_cfg_o) == `HAP_PLL_CFG_A) else $error("pll order");
    a_no_early_write: assert property (
        !we_n_o |-> done_r) else $error("write before init done");
    a_poll_only_sig: assert property (
        !oe_n_o && !done_r |-> addr_o == '0) else $error("early read");
    a_one_select: assert property (
        $onehot0(~cs_n_o)) else $error("several chip selects");
    a_cs_frames: assert property (
        !oe_n_o || !we_n_o |-> cs_n_o != 4'hF && $past(cs_n_o) != 4'hF)
        else $error("strobe outside select");
    a_data_drive: assert property (
        !oe_n_o || !we_n_o |-> data_oe_o == oe_n_o)
        else $error("data drive wrong");
    a_cs_in_reset: assert property (
        !dev_rst_n_o |-> cs_n_o == 4'hF) else $error("select in reset");
    c_read: cover property ($rose(oe_n_o));
    c_write: cover property ($rose(we_n_o));
    c_done: cover property ($rose(done_r));
endmodule
bind hap_host_port hap_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .pll_cfg_o(pll_cfg_o),
    .dev_rst_n_o(dev_rst_n_o), .cs_n_o(cs_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o), .addr_o(addr_o), .data_oe_o(data_oe_o),
    .data_i(data_i));

// ===== sim/hap_dev_model.sv
// Behavioural model of the device behind the host port.
`timescale 1ns/100ps
`include "hap_consts.svh"
module hap_dev_model #(
    parameter int INIT_CYC = 1025
)(
    input  wire logic        clk_i,
    input  wire logic        dev_rst_n_i,
    input  wire logic [3:0]  cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o
);
    logic [10:0] init_cnt_r;
    logic [15:0] mem_r [16];
    logic [15:0] last_r;
    logic        sel;
    assign sel = cs_n_i != 4'hF;
    // Initialization counts clock cycles from hard reset release.
    always_ff @(posedge clk_i or negedge dev_rst_n_i) begin
        if (!dev_rst_n_i) begin
            init_cnt_r <= 11'h000;
        end else if (init_cnt_r != INIT_CYC[10:0]) begin
            init_cnt_r <= init_cnt_r + 11'h001;
        end
    end
    // Halfword writes; the signature word is read-only.
    always_ff @(posedge clk_i) begin
        if (sel && !we_n_i && addr_i != 16'h0000) begin
            mem_r[addr_i[3:0]] <= wdata_i;
        end
        last_r <= rdata_o;
    end
    // Released pins toggle every cycle so stale data never looks valid.
    always_comb begin
        if (sel && !oe_n_i && addr_i == 16'h0000) begin
            rdata_o = (init_cnt_r == INIT_CYC[10:0]) ? `HAP_SIG_DONE
                                                     : `HAP_SIG_BUSY;
        end else if (sel && !oe_n_i) begin
            rdata_o = mem_r[addr_i[3:0]];
        end else begin
            rdata_o = ~last_r;
        end
    end
endmodule

// ===== sim/hap_host_port_bench.sv
// Self-checking bench of the host port controller.
`timescale 1ns/100ps
`include "hap_consts.svh"
module hap_host_port_bench;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic        pll_lock_i = 1'b0;
    logic [31:0] avs_readdata_o, pll_cfg_o, d;
    logic        avs_waitrequest_o, dev_rst_n_o, oe_n_o, we_n_o, data_oe_o;
    logic [3:0]  cs_n_o, cs_seen = 4'h0;
    logic [15:0] addr_o, data_o, dev_q, pin;
    int          err_total = 0, n_compared = 0, cyc = 0, dev_cyc = 0;
    int          oe_run = 0, oe_last = 0, we_run = 0, we_last = 0;
    assign pin = data_oe_o ? data_o : dev_q;
    hap_host_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .pll_lock_i(pll_lock_i),
        .pll_cfg_o(pll_cfg_o), .dev_rst_n_o(dev_rst_n_o), .cs_n_o(cs_n_o),
        .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .data_i(pin));
    hap_dev_model u_dev (.clk_i(clk_i), .dev_rst_n_i(dev_rst_n_o),
        .cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .addr_i(addr_o), .wdata_i(pin), .rdata_o(dev_q));
    always #50 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    // Strobe lengths, init time and a hang limit well above the run.
    always @(posedge clk_i) begin
        cyc++;
        dev_cyc = dev_rst_n_o ? dev_cyc + 1 : 0;
        cs_seen |= ~cs_n_o;
        if (!oe_n_o) oe_run++;
        else if (oe_run != 0) begin
            oe_last = oe_run;
            oe_run = 0;
        end
        if (!we_n_o) we_run++;
        else if (we_run != 0) begin
            we_last = we_run;
            we_run = 0;
        end
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // Requests stay up until the edge that sees waitrequest low.
    task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= v;
        avs_write_i <= 1'b1;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
        avs_write_i <= 1'b0;
    endtask
    task automatic av_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
        v = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 60; k++) begin
            av_rd(`HAP_REG_STATUS, d);
            if (d[1] === 1'b0) break;
        end
        while (cs_n_o !== 4'hF) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        av_rd(`HAP_REG_WAITS, d);
        chk("waits", 32'h15, d);
        av_rd(4'h9, d);
        chk("unmapped", 32'h0, d);
        av_rd(`HAP_REG_SIG, d);
        chk("signature", 32'h0, d);
    endtask
    // Bad set-ups end in the error state with every select off.
    task automatic t_errs;
        logic [31:0] pads [3] = '{32'h7F, 32'h70, 32'h72};
        logic [31:0] ctls [3] = '{32'h19, 32'h13, 32'h03};
        av_wr(`HAP_REG_CMD, 32'h2);
        av_rd(`HAP_REG_STATUS, d);
        chk("refused", 32'h4, d & 32'h4);
        for (int i = 0; i < 3; i++) begin
            av_wr(`HAP_REG_PAD, pads[i]);
            av_wr(`HAP_REG_CTRL, ctls[i]);
            repeat (8) @(posedge clk_i);
            av_rd(`HAP_REG_STATUS, d);
            chk("error state", 32'h1000, d & 32'h1FF0);
            chk("selects", 32'hF, {28'h0, cs_n_o});
        end
        av_wr(`HAP_REG_CTRL, 32'h20);
    endtask
    task automatic t_start;
        cs_seen = 4'h0;
        av_wr(`HAP_REG_PAD, 32'h72);
        av_wr(`HAP_REG_WAITS, 32'h0);
        av_wr(`HAP_REG_CTRL, 32'h13);
        for (int k = 0; k < 50 && pll_cfg_o !== `HAP_PLL_CFG_A; k++)
            @(posedge clk_i);
        repeat (20) @(posedge clk_i);
        chk("cfg held", `HAP_PLL_CFG_A, pll_cfg_o);
        chk("dev reset", 32'h0, {31'h0, dev_rst_n_o});
        pll_lock_i <= 1'b1;
        for (int k = 0; k < 50 && dev_rst_n_o !== 1'b1; k++)
            @(posedge clk_i);
        chk("cfg final", `HAP_PLL_CFG_B, pll_cfg_o);
        repeat (100) @(posedge clk_i);
        av_rd(`HAP_REG_SIG, d);
        chk("busy sig", 32'h0, d);
        av_rd(`HAP_REG_STATUS, d);
        chk("polling", 32'h400, d & 32'h1FF0);
        for (int k = 0; k < 400; k++) begin
            av_rd(`HAP_REG_STATUS, d);
            if (d[0] === 1'b1) break;
        end
        chk("init time", 32'h1,
            {31'h0, dev_cyc >= 1025 && dev_cyc < 1070});
        av_rd(`HAP_REG_SIG, d);
        chk("done sig", 32'h0815, d);
        chk("select", 32'h2, {28'h0, cs_seen});
    endtask
    // Write then read back; clamped waits latched at start-up stay.
    task automatic t_access;
        logic [31:0] w [2] = '{32'h27, 32'h00};
        logic [15:0] wd [2] = '{16'hA55A, 16'h3CC3};
        for (int i = 0; i < 2; i++) begin
            av_wr(`HAP_REG_WAITS, w[i]);
            av_wr(`HAP_REG_ADDR, 32'h5 + 32'(i));
            av_wr(`HAP_REG_WDATA, {16'h0, wd[i]});
            av_wr(`HAP_REG_CMD, 32'h2);
            wait_idle();
            av_wr(`HAP_REG_CMD, 32'h1);
            wait_idle();
            av_rd(`HAP_REG_RDATA, d);
            chk("rdata", {16'h0, wd[i]}, {16'h0, d[15:0]});
            chk("read strobe", 32'h7, 32'(oe_last));
            chk("write strobe", 32'h3, 32'(we_last));
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_errs();
        t_start();
        t_access();
        test_done();
    end
endmodule
